/* include/ssr_pkg.sv */
// ssr_pkg: register map, field positions and character widths for the
// synchronous serial receive / client block.
// assumes an 8-bit register port with a 3-bit word index.
package ssr_pkg;
  localparam int ADDR_W = 3;   // register index width
  localparam int DATA_W = 8;   // register data width
  localparam int CHAR_W = 9;   // widest character incl. ninth bit
  localparam int FIFO_DEPTH = 2; // receive queue entries

  // register offsets
  localparam logic [2:0] OFS_BAUD   = 3'h0; // baud_control
  localparam logic [2:0] OFS_RXDATA = 3'h1; // receive_data
  localparam logic [2:0] OFS_RXSTAT = 3'h2; // receive_status_control
  localparam logic [2:0] OFS_DIVLO  = 3'h3; // baud_divisor_low
  localparam logic [2:0] OFS_DIVHI  = 3'h4; // baud_divisor_high
  localparam logic [2:0] OFS_TXSTAT = 3'h5; // transmit_status_control
  localparam logic [2:0] OFS_TXHOLD = 3'h6; // transmit_holding
  localparam logic [2:0] OFS_IRQ    = 3'h7; // irq flags and enables

  // baud_control fields
  localparam int B_WIDE = 3;   // baud_wide_divisor
  // receive_status_control fields
  localparam int R_SERIAL_PORT_ENABLE = 7;   // serial_port_enable
  localparam int R_RX9  = 6;   // ninth_bit_receive_enable
  localparam int R_SINGLE_RECEIVE_ENABLE = 5;   // single_receive_enable
  localparam int R_CONTINUOUS_RECEIVE_ENABLE = 4;   // continuous_receive_enable
  localparam int R_OVERRUN_FLAG = 1;   // overrun_flag
  localparam int R_RECEIVED_NINTH_BIT = 0;   // received_ninth_bit
  // transmit_status_control fields
  localparam int T_CLOCK_SOURCE_SELECT = 7;   // clock_source_select
  localparam int T_TX9  = 6;   // ninth bit transmit enable
  localparam int T_TXEN = 5;   // transmit enable
  localparam int T_SYNC = 4;   // synchronous mode
  localparam int T_BAUD_HIGH_SPEED = 2;   // baud_high_speed
  localparam int T_TRMT = 1;   // shift register empty
  localparam int T_TX9D = 0;   // ninth bit to send
  // irq register fields
  localparam int I_RCIF = 0;   // receive_irq_flag
  localparam int I_TXIF = 1;   // transmit_irq_flag
  localparam int I_RCIE = 2;   // receive_irq_enable
  localparam int I_TXIE = 3;   // transmit_irq_enable
  localparam int I_PEIE = 4;   // peripheral_irq_enable
  localparam int I_GIE  = 5;   // global_irq_enable

  // bits per character
  localparam logic [3:0] NBITS_8 = 4'h8;
  localparam logic [3:0] NBITS_9 = 4'h9;
  localparam logic [7:0] REG_RST = 8'h00; // reset value of all registers but irq and transmit_status_control, which read 8'h02
endpackage

/* include/ssr_pin_if.sv */
// ssr_pin_if: synchronised pin events from the pin sampler to the core.
// assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface ssr_pin_if;
  logic ck_rise;  // leading edge of clock line seen
  logic ck_fall;  // trailing edge of clock line seen
  logic dt_level; // synchronised data line level
  modport src (output ck_rise, output ck_fall, output dt_level);
  modport dst (input ck_rise, input ck_fall, input dt_level);
endinterface

/* verilog/ssr_pin_sync.sv */
// ssr_pin_sync: two-flop synchronisers for the clock and data lines and
// edge detection on the clock line.
// assumes pins are asynchronous to clk_in and slower than half its rate.
`timescale 1ns/100ps
module ssr_pin_sync (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic ck_pin_in,
  input  wire logic dt_pin_in,
  ssr_pin_if.src    pin
);
  // sampler state
  typedef struct packed {
    logic [2:0] ck; // [0],[1] synchroniser, [2] edge history
    logic [1:0] dt; // data synchroniser
  } ssr_sync_s;

  ssr_sync_s s_ff;  // registered state
  ssr_sync_s nxt_s; // next state

  // shift the pins in
  always_comb begin
    nxt_s = s_ff;
    nxt_s.ck = {s_ff.ck[1:0], ck_pin_in};
    nxt_s.dt = {s_ff.dt[0], dt_pin_in};
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // edges only from the second stage onward
  assign pin.ck_rise  = s_ff.ck[1] & ~s_ff.ck[2];
  assign pin.ck_fall  = ~s_ff.ck[1] & s_ff.ck[2];
  assign pin.dt_level = s_ff.dt[1];
endmodule

/* verilog/ssr_core.sv */
// ssr_core: synchronous serial port, receive path with two-entry queue,
// host clock generation for reception, client transmit with holding.
// assumes a single-cycle register port on clk_in and pins from outside.
// Operation
// - client takes clock from pin, never drives
// - data changes on leading, sampled trailing
// - one bit per clock, bits per character
// - two-character receive queue before data register
// - third character when full sets overrun
// - overrun keeps queue, blocks further reception
// - overrun clears by read in single mode
// - overrun clears on continuous or port disable
// - ninth bit enable shifts nine bits
// - ninth bit shows oldest queued character
// - character done sets receive flag, request
// - client transmits when both receive enables clear
// - second word waits, transmit flag clear
// - after shift out, load second, set flag
// - transmit flag wakes, vectors with global
// - single receive clocks one character, self-clears
// - continuous clear mid-character stops, discards
// - sample data on trailing clock edge
`timescale 1ns/100ps
module ssr_core #(
  parameter int DEPTH = ssr_pkg::FIFO_DEPTH  // receive queue entries
) (
  input  wire logic                        clk_in,
  input  wire logic                        nrst_in,
  input  wire logic [ssr_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [ssr_pkg::DATA_W-1:0]  wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output logic      [ssr_pkg::DATA_W-1:0]  rdata_out,
  input  wire logic                        ck_pin_in,
  output logic                             ck_pin_out,
  output logic                             ck_pin_oe_out,
  input  wire logic                        dt_pin_in,
  output logic                             dt_pin_out,
  output logic                             dt_pin_oe_out,
  input  wire logic                        sleep_in,
  output logic                             irq_req_out,
  output logic                             wake_out,
  output logic                             vector_out
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // head index width
  localparam int CW = $clog2(DEPTH + 1);                // count width
  localparam int NW = ssr_pkg::CHAR_W;

  // complete block state
  typedef struct packed {
    logic                     wide;     // baud_wide_divisor
    logic [7:0]               div_lo;   // baud_divisor_low
    logic [7:0]               div_hi;   // baud_divisor_high
    logic                     serial_port_enable;     // serial_port_enable
    logic                     rx9;      // ninth_bit_receive_enable
    logic                     single_receive_enable;     // single_receive_enable
    logic                     continuous_receive_enable;     // continuous_receive_enable
    logic                     overrun_flag;     // overrun_flag
    logic                     overrun_flag_sgl; // overrun hit in single mode
    logic                     clock_source_select;     // clock_source_select
    logic                     tx9;      // nine bit transmit
    logic                     txen;     // transmit enable
    logic                     sync;     // synchronous mode
    logic                     baud_high_speed;     // baud_high_speed
    logic                     tx9d;     // ninth bit to send
    logic                     rcie;     // receive_irq_enable
    logic                     txie;     // transmit_irq_enable
    logic                     peie;     // peripheral_irq_enable
    logic                     gie;      // global_irq_enable
    logic [DEPTH-1:0][NW-1:0] fifo;     // receive queue storage
    logic [IW-1:0]            head;     // oldest entry
    logic [CW-1:0]            cnt;      // entries held
    logic [NW-1:0]            receive_shift_register;      // receive_shift_register
    logic [3:0]               rx_bits;  // bits received
    logic [15:0]              bcnt;     // baud counter
    logic                     ck;       // host clock level
    logic [NW-1:0]            hold;     // transmit_holding
    logic                     hold_full;
    logic [NW-1:0]            transmit_shift_register;      // transmit_shift_register
    logic                     tsr_busy;
    logic [3:0]               tx_bits;  // bits sent
    logic                     dt_out;   // data line drive value
    logic [7:0]               rdata;    // read data register
  } ssr_core_s;

  ssr_core_s s_ff;  // registered state
  ssr_core_s nxt_s; // next state

  ssr_pin_if pin (); // synchronised pin events

  // pin sampler
  ssr_pin_sync u_sync (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .ck_pin_in (ck_pin_in),
    .dt_pin_in (dt_pin_in),
    .pin       (pin)
  );

  logic          active;  // port enabled in synchronous mode
  logic          host;    // internal clock source
  logic          rx_run;  // receiver taking bits
  logic          tx_mode; // client transmit selected
  logic          rcif;    // receive_irq_flag
  logic          txif;    // transmit_irq_flag
  logic [15:0]   divisor; // selected divisor
  logic [3:0]    rx_nb;   // receive character length
  logic [3:0]    tx_nb;   // transmit character length
  logic [IW-1:0] tail;    // next free entry

  // mode decode
  assign active  = s_ff.serial_port_enable & s_ff.sync;
  assign host    = active & s_ff.clock_source_select;
  assign rx_run  = active & (s_ff.single_receive_enable | s_ff.continuous_receive_enable) & ~s_ff.overrun_flag;
  assign tx_mode = active & ~s_ff.clock_source_select & s_ff.txen & ~(s_ff.single_receive_enable | s_ff.continuous_receive_enable);
  assign rcif    = (s_ff.cnt != '0);
  assign txif    = ~s_ff.hold_full;
  assign divisor = s_ff.wide ? {s_ff.div_hi, s_ff.div_lo} : {8'h00, s_ff.div_lo};
  assign rx_nb   = s_ff.rx9 ? ssr_pkg::NBITS_9 : ssr_pkg::NBITS_8;
  assign tx_nb   = s_ff.tx9 ? ssr_pkg::NBITS_9 : ssr_pkg::NBITS_8;
  assign tail    = IW'((int'(s_ff.head) + int'(s_ff.cnt)) % DEPTH);

  // next-state logic
  always_comb begin
    logic          lead;   // leading clock edge
    logic          trail;  // trailing clock edge
    logic          push;   // character into queue
    logic          pop;    // software read of queue
    logic [NW-1:0] shift;  // receive shift after sample
    logic [NW-1:0] rxchar; // completed character
    logic [7:0]    rv;     // read value
    lead   = 1'b0;
    trail  = 1'b0;
    push   = 1'b0;
    pop    = 1'b0;
    shift  = '0;
    rxchar = '0;
    rv     = ssr_pkg::REG_RST;
    nxt_s  = s_ff;
    nxt_s.rdata = ssr_pkg::REG_RST; // read data stand one cycle only

    // host clock: half period per divisor match, idles low
    if (host && rx_run) begin
      if (s_ff.bcnt == divisor) begin
        nxt_s.bcnt = 16'h0000;
        nxt_s.ck   = ~s_ff.ck;
        lead       = ~s_ff.ck; // rising is leading
        trail      = s_ff.ck;
      end else begin
        nxt_s.bcnt = s_ff.bcnt + 16'h0001;
      end
    end else begin
      nxt_s.bcnt = 16'h0000;
      nxt_s.ck   = 1'b0; // clock stops at once
    end
    // client: edges of the synchronised clock line
    if (active && !s_ff.clock_source_select) begin
      lead  = pin.ck_rise;
      trail = pin.ck_fall;
    end

    // receive shifting
    if (!rx_run) begin
      nxt_s.rx_bits = 4'h0; // partial character dropped
      nxt_s.receive_shift_register     = '0;
    end else if (trail) begin
      shift = {pin.dt_level, s_ff.receive_shift_register[NW-1:1]}; // sample on trailing
      nxt_s.receive_shift_register = shift;
      nxt_s.rx_bits = s_ff.rx_bits + 4'h1; // one bit per clock
      if (s_ff.rx_bits + 4'h1 == rx_nb) begin
        rxchar = s_ff.rx9 ? shift : {1'b0, shift[NW-1:1]};
        nxt_s.rx_bits = 4'h0;
        nxt_s.receive_shift_register = '0;
        if (int'(s_ff.cnt) < DEPTH) begin
          push = 1'b1;
        end else begin
          nxt_s.overrun_flag = 1'b1; // queue kept as is
          nxt_s.overrun_flag_sgl = s_ff.single_receive_enable & ~s_ff.continuous_receive_enable;
        end
        if (host) begin
          nxt_s.single_receive_enable = 1'b0; // one character only
        end
      end
    end

    // register read
    if (rd_in) begin
      unique case (addr_in)
        ssr_pkg::OFS_BAUD: begin
          rv[ssr_pkg::B_WIDE] = s_ff.wide;
        end
        ssr_pkg::OFS_RXDATA: begin
          rv  = s_ff.fifo[s_ff.head][7:0];
          pop = rcif; // advances the queue
          if (s_ff.overrun_flag && s_ff.overrun_flag_sgl) begin
            nxt_s.overrun_flag = 1'b0;
          end
        end
        ssr_pkg::OFS_RXSTAT: begin
          rv[ssr_pkg::R_SERIAL_PORT_ENABLE] = s_ff.serial_port_enable;
          rv[ssr_pkg::R_RX9]  = s_ff.rx9;
          rv[ssr_pkg::R_SINGLE_RECEIVE_ENABLE] = s_ff.single_receive_enable;
          rv[ssr_pkg::R_CONTINUOUS_RECEIVE_ENABLE] = s_ff.continuous_receive_enable;
          rv[ssr_pkg::R_OVERRUN_FLAG] = s_ff.overrun_flag;
          rv[ssr_pkg::R_RECEIVED_NINTH_BIT] = rcif & s_ff.fifo[s_ff.head][NW-1];
        end
        ssr_pkg::OFS_DIVLO: begin
          rv = s_ff.div_lo;
        end
        ssr_pkg::OFS_DIVHI: begin
          rv = s_ff.div_hi;
        end
        ssr_pkg::OFS_TXSTAT: begin
          rv[ssr_pkg::T_CLOCK_SOURCE_SELECT] = s_ff.clock_source_select;
          rv[ssr_pkg::T_TX9]  = s_ff.tx9;
          rv[ssr_pkg::T_TXEN] = s_ff.txen;
          rv[ssr_pkg::T_SYNC] = s_ff.sync;
          rv[ssr_pkg::T_BAUD_HIGH_SPEED] = s_ff.baud_high_speed;
          rv[ssr_pkg::T_TRMT] = ~s_ff.tsr_busy;
          rv[ssr_pkg::T_TX9D] = s_ff.tx9d;
        end
        ssr_pkg::OFS_TXHOLD: begin
          rv = ssr_pkg::REG_RST; // write only
        end
        ssr_pkg::OFS_IRQ: begin
          rv[ssr_pkg::I_RCIF] = rcif;
          rv[ssr_pkg::I_TXIF] = txif;
          rv[ssr_pkg::I_RCIE] = s_ff.rcie;
          rv[ssr_pkg::I_TXIE] = s_ff.txie;
          rv[ssr_pkg::I_PEIE] = s_ff.peie;
          rv[ssr_pkg::I_GIE]  = s_ff.gie;
        end
      endcase
      nxt_s.rdata = rv;
    end

    // queue update, push and pop may meet
    if (push) begin
      nxt_s.fifo[tail] = rxchar;
    end
    if (pop) begin
      nxt_s.head = (s_ff.head == IW'(DEPTH - 1)) ? '0 : s_ff.head + IW'(1);
    end
    nxt_s.cnt = s_ff.cnt + CW'(push) - CW'(pop);

    // transmit: holding moves as soon as the shifter is free
    if (!tx_mode) begin
      nxt_s.tsr_busy = 1'b0;
      nxt_s.tx_bits  = 4'h0;
    end else if (!s_ff.tsr_busy) begin
      if (s_ff.hold_full) begin
        nxt_s.transmit_shift_register       = s_ff.hold;
        nxt_s.tsr_busy  = 1'b1;
        nxt_s.hold_full = 1'b0; // transmit flag rises now
      end
    end else if (lead && s_ff.tx_bits != tx_nb) begin
      nxt_s.dt_out  = s_ff.transmit_shift_register[0]; // change on leading edge
      nxt_s.transmit_shift_register     = {1'b0, s_ff.transmit_shift_register[NW-1:1]};
      nxt_s.tx_bits = s_ff.tx_bits + 4'h1;
    end else if (trail && s_ff.tx_bits == tx_nb) begin
      nxt_s.tsr_busy = 1'b0; // last bit taken by partner
      nxt_s.tx_bits  = 4'h0;
    end

    // register write
    if (wr_in) begin
      unique case (addr_in)
        ssr_pkg::OFS_BAUD: begin
          nxt_s.wide = wdata_in[ssr_pkg::B_WIDE];
        end
        ssr_pkg::OFS_RXDATA: begin
          nxt_s.wide = nxt_s.wide; // read only
        end
        ssr_pkg::OFS_RXSTAT: begin
          nxt_s.serial_port_enable = wdata_in[ssr_pkg::R_SERIAL_PORT_ENABLE];
          nxt_s.rx9  = wdata_in[ssr_pkg::R_RX9];
          nxt_s.single_receive_enable = wdata_in[ssr_pkg::R_SINGLE_RECEIVE_ENABLE];
          nxt_s.continuous_receive_enable = wdata_in[ssr_pkg::R_CONTINUOUS_RECEIVE_ENABLE];
          if (!wdata_in[ssr_pkg::R_CONTINUOUS_RECEIVE_ENABLE] && s_ff.overrun_flag && !s_ff.overrun_flag_sgl) begin
            nxt_s.overrun_flag = 1'b0; // continuous cleared
          end
        end
        ssr_pkg::OFS_DIVLO: begin
          nxt_s.div_lo = wdata_in;
        end
        ssr_pkg::OFS_DIVHI: begin
          nxt_s.div_hi = wdata_in;
        end
        ssr_pkg::OFS_TXSTAT: begin
          nxt_s.clock_source_select = wdata_in[ssr_pkg::T_CLOCK_SOURCE_SELECT];
          nxt_s.tx9  = wdata_in[ssr_pkg::T_TX9];
          nxt_s.txen = wdata_in[ssr_pkg::T_TXEN];
          nxt_s.sync = wdata_in[ssr_pkg::T_SYNC];
          nxt_s.baud_high_speed = wdata_in[ssr_pkg::T_BAUD_HIGH_SPEED];
          nxt_s.tx9d = wdata_in[ssr_pkg::T_TX9D];
        end
        ssr_pkg::OFS_TXHOLD: begin
          if (!nxt_s.hold_full) begin
            nxt_s.hold      = {s_ff.tx9d, wdata_in}; // second word waits
            nxt_s.hold_full = 1'b1;
          end
        end
        ssr_pkg::OFS_IRQ: begin
          nxt_s.rcie = wdata_in[ssr_pkg::I_RCIE];
          nxt_s.txie = wdata_in[ssr_pkg::I_TXIE];
          nxt_s.peie = wdata_in[ssr_pkg::I_PEIE];
          nxt_s.gie  = wdata_in[ssr_pkg::I_GIE];
        end
      endcase
    end

    // port disabled: queue, overrun, receive and transmit state held in reset
    if (!s_ff.serial_port_enable) begin
      nxt_s.overrun_flag      = 1'b0;
      nxt_s.overrun_flag_sgl  = 1'b0;
      nxt_s.cnt       = '0;
      nxt_s.head      = '0;
      nxt_s.receive_shift_register       = '0;
      nxt_s.rx_bits   = 4'h0;
      nxt_s.hold_full = 1'b0;
      nxt_s.tsr_busy  = 1'b0;
      nxt_s.tx_bits   = 4'h0;
      nxt_s.dt_out    = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // pins: clock driven only as host, data only in client transmit
  assign ck_pin_out    = s_ff.ck;
  assign ck_pin_oe_out = host;
  assign dt_pin_out    = s_ff.dt_out;
  assign dt_pin_oe_out = tx_mode;
  assign rdata_out     = s_ff.rdata;

  // request, wake and vector
  assign irq_req_out = s_ff.peie & ((rcif & s_ff.rcie) | (txif & s_ff.txie));
  assign wake_out    = sleep_in & irq_req_out;
  assign vector_out  = irq_req_out & s_ff.gie;
endmodule

/* tb/ssr_core_props.sv */
// ssr_core_props: port-level checks bound onto the serial core.
// assumes the core's port names and a bench-resolved clock line.
`timescale 1ns/100ps
module ssr_core_props (
  input  wire logic                       clk_in,        // system clock
  input  wire logic                       nrst_in,       // reset, active low
  input  wire logic                       rd_in,         // read strobe
  input  wire logic [ssr_pkg::DATA_W-1:0] rdata_out,     // read data
  input  wire logic                       ck_pin_in,     // clock line level
  input  wire logic                       ck_pin_out,    // host clock
  input  wire logic                       ck_pin_oe_out, // clock driver on
  input  wire logic                       dt_pin_out,    // data bit
  input  wire logic                       dt_pin_oe_out, // data driver on
  input  wire logic                       sleep_in,      // asleep
  input  wire logic                       irq_req_out,   // request
  input  wire logic                       wake_out,      // wake
  input  wire logic                       vector_out     // vector
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // trailing edge on the line while the core sends
  sequence s_ck_fall;
    dt_pin_oe_out && $fell(ck_pin_in);
  endsequence
  // data quiet until the next leading edge can land
  sequence s_dt_quiet;
    $stable(dt_pin_out)[*3];
  endsequence
  property p_dt_hold; s_ck_fall |=> s_dt_quiet; endproperty
  property p_wake_on; sleep_in && irq_req_out |-> wake_out; endproperty
  property p_wake_awake; !sleep_in |-> !wake_out; endproperty
  property p_wake_req; wake_out |-> irq_req_out; endproperty
  property p_vec; vector_out |-> irq_req_out; endproperty
  property p_rd_zero; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
  property p_oe_excl; ck_pin_oe_out |-> !dt_pin_oe_out; endproperty
  property p_ck_start; $rose(ck_pin_oe_out) |-> !ck_pin_out; endproperty
  a_dt_hold: assert property (p_dt_hold) else $error("data moved after trailing edge");
  a_wake_on: assert property (p_wake_on) else $error("request in sleep without wake");
  a_wake_awake: assert property (p_wake_awake) else $error("wake while awake");
  a_wake_req: assert property (p_wake_req) else $error("wake without request");
  a_vec: assert property (p_vec) else $error("vector without request");
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside its cycle");
  a_oe_excl: assert property (p_oe_excl) else $error("clock and data both driven");
  a_ck_start: assert property (p_ck_start) else $error("host clock not starting low");
endmodule
bind ssr_core ssr_core_props chk_u (.clk_in, .nrst_in, .rd_in, .rdata_out, .ck_pin_in, .ck_pin_out,
  .ck_pin_oe_out, .dt_pin_out, .dt_pin_oe_out, .sleep_in, .irq_req_out, .wake_out, .vector_out);

/* tb/ssr_peer.sv */
// ssr_peer: far-side synchronous serial party, host or client role.
// assumes the bench resolves the shared clock and data lines.
`timescale 1ns/100ps
module ssr_peer (
  input  wire logic ck_line_in, // resolved clock line
  input  wire logic dt_line_in, // resolved data line
  output logic      ck_out,     // clock when peer is source
  output logic      dt_out      // data when peer drives
);
  logic       busy = 1'b0;     // own frame running
  logic       serve = 1'b0;    // answering the core's clock
  logic [8:0] srv_d = 9'h000;  // bits to send, lsb first
  // clock stands low between frames
  initial begin
    ck_out = 1'b0;
    dt_out = 1'b0;
  end
  // idle data wanders so a stale level never passes for a bit
  always #30 if (!busy && !serve) dt_out = ~dt_out;
  // client role: next bit on each leading edge
  always @(posedge ck_line_in) begin
    if (serve) begin
      dt_out = srv_d[0];
      srv_d = {~srv_d[0], srv_d[8:1]};
    end
  end
  // host role: n clocks of 80 ns, change on leading, sample on trailing
  task automatic xfer(input logic [8:0] d, input int n, output logic [8:0] got);
    got = 9'h000;
    busy = 1'b1;
    #2; // keep line edges off the sampling clock edge
    for (int i = 0; i < n; i++) begin
      ck_out = 1'b1;
      dt_out = d[i];
      #50 ck_out = 1'b0;
      got[i] = dt_line_in;
      #30;
    end
    busy = 1'b0;
  endtask
endmodule

/* tb/ssr_core_tb_top.sv */
// ssr_core_tb_top: self-checking bench for the serial core.
// assumes ssr_peer as far side and ssr_core_props bound on.
`timescale 1ns/100ps
module ssr_core_tb_top;
  logic       clk_in = 1'b0;    // 100 MHz clock
  logic       nrst_in = 1'b0;   // reset, active low
  logic [2:0] addr_in = 3'h0;   // register index
  logic [7:0] wdata_in = 8'h00; // write data
  logic       wr_in = 1'b0;     // write strobe
  logic       rd_in = 1'b0;     // read strobe
  logic       sleep_in = 1'b0;  // asleep
  logic [7:0] rdata_out;        // read data
  logic       ck_pin_out, ck_pin_oe_out, dt_pin_out, dt_pin_oe_out; // pin drivers
  logic       irq_req_out, wake_out, vector_out; // requests
  logic       peer_ck, peer_dt; // far side drives
  logic [8:0] c[4];             // random characters
  logic [8:0] got;              // far side capture
  logic [7:0] r;                // read value
  logic [8:0] exp_q[$];         // model of the receive queue
  int         errors = 0;       // mismatches
  int         comparisons = 0;  // compares
  int         cycles = 0;       // run length
  int         ck_rises = 0;     // host leading edges
  int         n0;               // rise mark
  integer     seed = 32'h001d;  // random seed
  // shared lines: a driving core wins, else the far side
  wire        ck_line = ck_pin_oe_out ? ck_pin_out : peer_ck;
  wire        dt_line = dt_pin_oe_out ? dt_pin_out : peer_dt;
  always #5 clk_in = ~clk_in;
  ssr_core dut_u (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .ck_pin_in(ck_line), .ck_pin_out, .ck_pin_oe_out, .dt_pin_in(dt_line), .dt_pin_out,
    .dt_pin_oe_out, .sleep_in, .irq_req_out, .wake_out, .vector_out);
  ssr_peer peer_u (.ck_line_in(ck_line), .dt_line_in(dt_line), .ck_out(peer_ck), .dt_out(peer_dt));
  // count leading edges only while the core drives the clock
  always @(posedge ck_line) begin
    if (ck_pin_oe_out) ck_rises++;
  end
  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      print_verdict();
    end
  end
  // compare one result
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // one-cycle read, data stands in the next cycle only
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    rd(a, r);
    check({1'b0, r}, {1'b0, e});
  endtask
  // ninth bit first, then the low byte pops the oldest entry
  task automatic pop(input logic [7:0] st);
    rdc(ssr_pkg::OFS_RXSTAT, st | {7'h00, exp_q[0][8]});
    rdc(ssr_pkg::OFS_RXDATA, exp_q[0][7:0]);
    void'(exp_q.pop_front());
  endtask
  // bounded wait for host leading edges
  task automatic upto(input int n);
    for (int i = 0; i < 600 && ck_rises < n; i++) @(posedge clk_in);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    rdc(ssr_pkg::OFS_RXSTAT, 8'h00);
    rdc(ssr_pkg::OFS_IRQ, 8'h02);
    wr(ssr_pkg::OFS_RXSTAT, 8'h03);
    rdc(ssr_pkg::OFS_RXSTAT, 8'h00);
    r = 8'($random(seed));
    wr(ssr_pkg::OFS_DIVHI, r);
    rdc(ssr_pkg::OFS_DIVHI, r);
    // host single receive, 8-cycle half periods, third char overruns
    wr(ssr_pkg::OFS_DIVLO, 8'h07);
    wr(ssr_pkg::OFS_TXSTAT, 8'h90);
    wr(ssr_pkg::OFS_RXSTAT, 8'h80);
    wr(ssr_pkg::OFS_IRQ, 8'h14);
    peer_u.serve = 1'b1;
    for (int i = 0; i < 3; i++) begin
      c[i] = 9'($random(seed)) & 9'h0ff;
      peer_u.srv_d = c[i];
      wr(ssr_pkg::OFS_RXSTAT, 8'ha0);
      upto(8 * i + 8);
      repeat (30) @(posedge clk_in);
      check(9'(ck_rises), 9'(8 * i + 8));
      if (i < 2) exp_q.push_back(c[i]);
    end
    pop(8'h82);
    rdc(ssr_pkg::OFS_RXSTAT, 8'h80);
    pop(8'h80);
    // continuous receive dropped mid-character
    n0 = ck_rises;
    wr(ssr_pkg::OFS_RXSTAT, 8'h90);
    upto(n0 + 3);
    wr(ssr_pkg::OFS_RXSTAT, 8'h80);
    repeat (40) @(posedge clk_in);
    check(9'(ck_rises), 9'(n0 + 3));
    rdc(ssr_pkg::OFS_IRQ, 8'h16);
    // client continuous receive of nine-bit chars while asleep
    wr(ssr_pkg::OFS_TXSTAT, 8'h10);
    peer_u.serve = 1'b0;
    wr(ssr_pkg::OFS_RXSTAT, 8'hd0);
    sleep_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      c[i] = 9'($random(seed));
      peer_u.xfer(c[i], 9, got);
      repeat (5) @(posedge clk_in);
      if (i < 2) exp_q.push_back(c[i]);
      if (i == 0) check({6'h00, ck_pin_oe_out, irq_req_out, wake_out}, 9'h003);
      if (i == 2) pop(8'hd2);
      if (i == 2) pop(8'hd2);
    end
    rdc(ssr_pkg::OFS_IRQ, 8'h16);
    wr(ssr_pkg::OFS_RXSTAT, 8'hc0);
    rd(ssr_pkg::OFS_RXSTAT, r);
    check({1'b0, r & 8'hfe}, 9'h0c0);
    // client transmit: two words written, still asleep
    wr(ssr_pkg::OFS_RXSTAT, 8'h80);
    wr(ssr_pkg::OFS_TXSTAT, 8'h30);
    wr(ssr_pkg::OFS_IRQ, 8'h38);
    wr(ssr_pkg::OFS_TXHOLD, c[0][7:0]);
    wr(ssr_pkg::OFS_TXHOLD, c[1][7:0]);
    repeat (3) @(posedge clk_in);
    check({7'h00, dt_pin_oe_out, irq_req_out}, 9'h002);
    for (int i = 0; i < 2; i++) begin
      peer_u.xfer(9'h000, 8, got);
      repeat (5) @(posedge clk_in);
      check({1'b0, got[7:0]}, {1'b0, c[i][7:0]});
      check({7'h00, wake_out, vector_out}, 9'h003);
    end
    rdc(ssr_pkg::OFS_TXSTAT, 8'h32);
    wr(ssr_pkg::OFS_BAUD, 8'hff);
    rdc(ssr_pkg::OFS_BAUD, 8'h08);
    print_verdict();
  end
endmodule
